// file: hw/lsp_pkg.sv
package lsp_pkg;

  // Low nibble of the logic group opcodes.
  localparam logic [3:0] NIB_TEST = 4'h3;
  localparam logic [3:0] NIB_SET2 = 4'h8;
  localparam logic [3:0] NIB_SET3 = 4'h9;
  localparam logic [3:0] NIB_CLR2 = 4'hA;
  localparam logic [3:0] NIB_CLR3 = 4'hB;
  localparam logic [3:0] NIB_XOR2 = 4'hC;
  localparam logic [3:0] NIB_XOR3 = 4'hD;
  // Operand size code held in opcode bits 6:5.
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  // Whole opcodes of the shift, rotate and evaluation group.
  localparam logic [7:0] OPC_ARITH_SHIFT_LONG = 8'h78;
  localparam logic [7:0] OPC_ARITH_SHIFT_QUAD = 8'h97;
  localparam logic [7:0] OPC_ROTATE_LONG = 8'h9C;
  localparam logic [7:0] OPC_HORNER_SINGLE = 8'h55;
  localparam logic [7:0] OPC_HORNER_DOUBLE = 8'h75;
  // Evaluation limits, table strides and the reserved operand pattern.
  localparam logic [15:0] DEGREE_LIMIT = 16'h001F;
  localparam logic [31:0] STEP_SINGLE = 32'h0000_0004;
  localparam logic [31:0] STEP_DOUBLE = 32'h0000_0008;
  localparam logic [31:0] RSVD_PATTERN = 32'h0000_8000;
  // Floating format: excess-128 exponent, truncation and rounding points.
  localparam logic [7:0] EXP_BIAS = 8'h80;
  localparam logic [11:0] EXP_MAX = 12'h0FF;
  localparam logic [63:0] TRUNC_SINGLE = 64'hFFFF_FFFF_0000_0000;
  localparam logic [54:0] FRAC_SINGLE = 55'h7F_FFFF_0000_0000;
  localparam logic [67:0] RND_ADD_SINGLE = 68'h0_0000_0400_0000_0000;
  localparam logic [67:0] RND_ADD_DOUBLE = 68'h0_0000_0000_0000_0400;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_MAC = 2'b10
  } lsp_state_t;

  // Condition codes as seen by the status longword.
  typedef struct packed {logic n; logic z; logic v; logic c;} lsp_cc_t;
  // Exception conditions raised with done.
  typedef struct packed {logic int_ovf; logic flt_ovf; logic flt_unf; logic rsvd_op;} lsp_exc_t;
  // Operation request presented with start.
  typedef struct packed {
    logic [7:0] opcode;
    logic [31:0] mask;
    logic [63:0] src;
    logic [63:0] dst;
    logic [7:0] cnt;
    logic [63:0] arg;
    logic [15:0] degree;
    logic [31:0] tbladdr;
  } lsp_req_t;
  // Working registers 2 to 5 after an evaluation.
  typedef struct packed {logic [31:0] r2; logic [31:0] r3; logic [31:0] r4; logic [31:0] r5;} lsp_regs_t;

  // A floating datum with sign set and exponent zero is the reserved operand.
  function automatic logic lsp_is_rsvd(input logic [63:0] x);
    return x[15] & (x[14:7] == 8'h00);
  endfunction : lsp_is_rsvd

endpackage : lsp_pkg

// file: hw/lsp_fmac.sv
`timescale 1ns/1ps
// Registered multiply-add res = a * b + c with one cycle of latency.
module lsp_fmac import lsp_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic go_i,
  input wire logic dbl_i,
  input wire logic [63:0] a_i,
  input wire logic [63:0] b_i,
  input wire logic [63:0] c_i,
  output logic valid_o,
  output logic [63:0] res_o,
  output logic ovf_o,
  output logic unf_o
);

  // Mantissa with hidden bit; the single form has no low fraction words.
  function automatic logic [55:0] mant(input logic [63:0] x, input logic dbl);
    return {1'b1, x[6:0], x[31:16], (dbl ? {x[47:32], x[63:48]} : 32'h0000_0000)};
  endfunction : mant

  // Alignment distance saturated so that a far operand shifts to zero.
  function automatic logic [6:0] sat(input logic signed [11:0] d);
    return (d > 12'sd66) ? 7'd67 : d[6:0];
  endfunction : sat

  logic [111:0] prod; // Full product of the two mantissas.
  logic [63:0] pm; // Product kept after truncation.
  logic signed [11:0] pe, ec, d, e, e_n; // Exponents during the step.
  logic [66:0] pv, cv, xv, yv, sum, nrm; // Aligned magnitudes with a carry bit.
  logic [66:0] m67; // Mantissa after rounding.
  logic [67:0] rnd; // Rounded sum with room for the carry.
  logic sp, sx, sy, sgn, zp, zc;
  logic [6:0] lz, pos;
  logic [54:0] frac;
  logic [63:0] res_d;
  logic ovf_d, unf_d;

  // One combined step: truncate the product, add, then normalise and round once.
  always_comb begin
    prod = mant(a_i, dbl_i) * mant(b_i, dbl_i);
    pe = $signed({4'h0, a_i[14:7]}) + $signed({4'h0, b_i[14:7]}) - $signed({4'h0, EXP_BIAS});
    pm = prod[111] ? prod[111:48] : prod[110:47];
    if (!prod[111]) begin
      pe = pe - 12'sd1;
    end
    // The fraction is cut, not rounded, before the add.
    if (!dbl_i) begin
      pm = pm & TRUNC_SINGLE;
    end
    zp = (a_i[14:7] == 8'h00) | (b_i[14:7] == 8'h00);
    zc = (c_i[14:7] == 8'h00);
    ec = $signed({4'h0, c_i[14:7]});
    sp = a_i[15] ^ b_i[15];
    pv = zp ? 67'h0 : {1'b0, pm, 2'b00};
    cv = zc ? 67'h0 : {1'b0, mant(c_i, dbl_i), 10'h000};
    d = pe - ec;
    // The larger exponent leads and the other operand is shifted down.
    if (zc | (!zp & (d >= 12'sd0))) begin
      e = pe;
      xv = pv;
      sx = sp;
      yv = cv >> sat(d);
      sy = c_i[15];
    end else begin
      e = ec;
      xv = cv;
      sx = c_i[15];
      yv = pv >> sat(-d);
      sy = sp;
    end
    if (sx == sy) begin
      sum = xv + yv;
      sgn = sx;
    end else if (xv >= yv) begin
      sum = xv - yv;
      sgn = sx;
    end else begin
      sum = yv - xv;
      sgn = sy;
    end
    pos = 7'd0;
    for (int i = 0; i < 67; i++) begin
      if (sum[i]) begin
        pos = 7'(i);
      end
    end
    lz = 7'd66 - pos;
    nrm = sum << lz;
    e_n = e + 12'sd1 - $signed({5'h00, lz});
    rnd = {1'b0, nrm} + (dbl_i ? RND_ADD_DOUBLE : RND_ADD_SINGLE);
    m67 = rnd[67] ? rnd[67:1] : rnd[66:0];
    if (rnd[67]) begin
      e_n = e_n + 12'sd1;
    end
    frac = dbl_i ? m67[65:11] : (m67[65:11] & FRAC_SINGLE);
    ovf_d = (sum != 67'h0) & (e_n > $signed(EXP_MAX));
    unf_d = (sum != 67'h0) & (e_n < 12'sd1);
    if ((sum == 67'h0) | ovf_d | unf_d) begin
      res_d = 64'h0;
    end else begin
      res_d = {frac[15:0], frac[31:16], frac[47:32], sgn, e_n[7:0], frac[54:48]};
    end
  end

  // The result is held in a register; valid follows go by one cycle.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      valid_o <= 1'b0;
      res_o <= 64'h0;
      ovf_o <= 1'b0;
      unf_o <= 1'b0;
    end else begin
      valid_o <= go_i;
      if (go_i) begin
        res_o <= res_d;
        ovf_o <= ovf_d;
        unf_o <= unf_d;
      end
    end
  end

endmodule : lsp_fmac

// file: hw/lsp_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Bit test: AND, set N Z, no write.
// - Bit set: OR mask, two or three operands.
// - Bit clear: AND with complemented mask, store.
// - XOR mask, write destination, V cleared.
// - Signed count shifts left, right or copies.
// - Left shift overflow when sign bits differ.
// - Too large left count gives zero.
// - Large right count gives all sign bits.
// - Rotate long by signed count, flags N Z.
// - Coefficients fetched highest first, rising addresses.
// - Multiply truncated, add, then round once.
// - Single: R0 result, R1 R2 zero, R3 end.
// - Double: R1 R0 result, others zero, R3 end.
// - Degree unsigned; above 31 is reserved operand.
// - First part done marks a fault on a coefficient after the top one.
// - Underflow zeroes result, loop continues, trap later.
// - Overflow stops; R0 reserved operand, R1 zero.
// - Overflow wins; pending underflow is dropped.
// - Evaluation flags follow R0; carry cleared.
module lsp_unit import lsp_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic start_i, // One-cycle request strobe.
  input wire lsp_req_t req_i, // Opcode and operands, valid with start.
  input wire logic carry_i, // Present carry flag, kept by most operations.
  input wire logic mem_ack_i, // Coefficient read data valid.
  input wire logic [63:0] mem_rdata_i, // Coefficient; low long only for single.
  output logic mem_req_o, // Coefficient read request, held until ack.
  output logic [31:0] mem_addr_o, // Byte address of the coefficient.
  output logic mem_dbl_o, // High for an eight-byte coefficient.
  output logic busy_o, // An evaluation is in progress.
  output logic done_o, // One-cycle completion strobe.
  output logic [63:0] result_o, // Destination value, or R1 and R0.
  output logic dst_wr_o, // Result is to be written back.
  output lsp_regs_t regs_o, // Registers 2 to 5 after an evaluation.
  output logic regs_wr_o, // Registers 2 to 5 are to be written.
  output lsp_cc_t cc_o, // Condition codes to store.
  output lsp_exc_t exc_o, // Exceptions to raise.
  output logic fpd_o // First part done flag to store.
);

  lsp_state_t state_q; // Evaluation sequencer state.
  logic dbl_q; // Double precision evaluation.
  logic [63:0] arg_q; // Captured argument.
  logic [63:0] acc_q; // Running result.
  logic [63:0] coef_q; // Coefficient for the step in flight.
  logic [31:0] ptr_q; // Address of the next coefficient.
  logic [5:0] left_q; // Steps still to run.
  logic first_q; // Waiting for the top coefficient.
  logic unf_q; // An underflow was seen in an earlier step.
  logic go_q; // Launches the multiply-add.
  logic mac_valid, mac_ovf, mac_unf;
  logic [63:0] mac_res;

  // Decode of the single-cycle operations.
  logic [7:0] opc;
  logic [3:0] nib;
  logic [1:0] sz;
  logic is_logic, is_poly, early_fault;
  logic [31:0] wmask, base, lres;
  logic [63:0] op_res;
  logic op_wr;
  lsp_cc_t op_cc;
  lsp_exc_t op_exc;
  // Shift work signals; the wide path makes every count land right.
  logic quad, sign, lovf;
  logic [63:0] src64, shr;
  logic [191:0] wide, shl;
  logic [7:0] mag;
  logic [63:0] rot;

  // Evaluation events seen in this cycle.
  logic [63:0] coef;
  logic fetch_ok, p_fault, p_first_end, mac_done, p_ovf, p_end_ok, start_ok;
  logic [63:0] fin_acc;
  logic [31:0] step, fin_ptr;

  always_comb begin
    opc = req_i.opcode;
    nib = opc[3:0];
    sz = opc[6:5];
    is_poly = (opc == OPC_HORNER_SINGLE) | (opc == OPC_HORNER_DOUBLE);
    // Test ops carry bit 4 and nibble 3; the others have bit 4 clear.
    is_logic = opc[7] & (sz != 2'h3) &
               ((opc[4] & (nib == NIB_TEST)) | (!opc[4] & (nib >= NIB_SET2) & (nib <= NIB_XOR3)));
    early_fault = (req_i.degree > DEGREE_LIMIT) | lsp_is_rsvd(req_i.arg);
  end

  // Logic group: one result path for all sizes, trimmed to the operand width.
  always_comb begin
    case (sz)
      SZ_BYTE: wmask = 32'h0000_00FF;
      SZ_WORD: wmask = 32'h0000_FFFF;
      default: wmask = 32'hFFFF_FFFF;
    endcase
    // Bit 0 picks the three-operand form, where a separate source is used.
    base = opc[0] ? req_i.src[31:0] : req_i.dst[31:0];
    case (nib)
      NIB_TEST: lres = req_i.src[31:0] & req_i.mask;
      NIB_SET2, NIB_SET3: lres = base | req_i.mask;
      NIB_CLR2, NIB_CLR3: lres = base & ~req_i.mask;
      default: lres = base ^ req_i.mask;
    endcase
    lres = lres & wmask;
  end

  // Arithmetic shift and rotate.
  always_comb begin
    quad = (opc == OPC_ARITH_SHIFT_QUAD);
    src64 = quad ? req_i.src : {{32{req_i.src[31]}}, req_i.src[31:0]};
    sign = src64[63];
    wide = {{128{sign}}, src64};
    // A count of minus 128 needs the eighth magnitude bit.
    mag = req_i.cnt[7] ? (~req_i.cnt + 8'h01) : req_i.cnt;
    shl = wide << mag; // zeros enter at the bottom
    // Past the width only zeros remain, so the low bits are zero.
    shr = $signed(src64) >>> mag; // sign copies fill from the top
    // Every bit that passed through the sign position must match the sign.
    if (req_i.cnt[7] | (req_i.cnt == 8'h00)) begin
      lovf = 1'b0;
    end else if (quad) begin
      lovf = (shl[191:63] != {129{sign}});
    end else begin
      lovf = (shl[191:31] != {161{sign}});
    end
    // Rotating left by the count modulo 32 also covers a negative count.
    rot = {req_i.src[31:0], req_i.src[31:0]} << req_i.cnt[4:0];
  end

  // Result, condition codes and exceptions of a single-cycle operation.
  always_comb begin
    op_res = 64'h0;
    op_wr = 1'b0;
    op_cc = '{n: 1'b0, z: 1'b0, v: 1'b0, c: carry_i};
    op_exc = '0;
    if (is_logic) begin
      op_res = {32'h0000_0000, lres};
      // The test forms only report flags and leave every operand alone.
      op_wr = (nib != NIB_TEST);
      op_cc.n = (sz == SZ_BYTE) ? lres[7] : ((sz == SZ_WORD) ? lres[15] : lres[31]);
      op_cc.z = (lres == 32'h0000_0000);
      op_cc.v = 1'b0;
    end else if ((opc == OPC_ARITH_SHIFT_LONG) | quad) begin
      if (req_i.cnt[7]) begin
        op_res = shr;
      end else begin
        op_res = shl[63:0];
      end
      if (!quad) begin
        op_res = {32'h0000_0000, op_res[31:0]};
      end
      op_wr = 1'b1;
      op_cc.n = quad ? op_res[63] : op_res[31];
      op_cc.z = (op_res == 64'h0);
      op_cc.v = lovf;
      op_cc.c = 1'b0;
      op_exc.int_ovf = lovf;
    end else if (opc == OPC_ROTATE_LONG) begin
      op_res = {32'h0000_0000, rot[63:32]};
      op_wr = 1'b1;
      op_cc.n = rot[63];
      op_cc.z = (rot[63:32] == 32'h0000_0000);
    end
  end

  // Evaluation events; a single coefficient uses only the low long.
  always_comb begin
    step = dbl_q ? STEP_DOUBLE : STEP_SINGLE;
    coef = dbl_q ? mem_rdata_i : {32'h0000_0000, mem_rdata_i[31:0]};
    start_ok = (state_q == ST_IDLE) & start_i;
    fetch_ok = (state_q == ST_FETCH) & mem_ack_i;
    p_fault = fetch_ok & lsp_is_rsvd(coef);
    p_first_end = fetch_ok & !p_fault & first_q & (left_q == 6'h00);
    mac_done = (state_q == ST_MAC) & mac_valid;
    p_ovf = mac_done & mac_ovf;
    p_end_ok = p_first_end | (mac_done & !mac_ovf & (left_q == 6'h01));
    // The pointer ends one entry past the constant coefficient.
    if (p_first_end) begin
      fin_acc = coef;
      fin_ptr = ptr_q + step;
    end else begin
      fin_acc = mac_unf ? 64'h0 : mac_res;
      fin_ptr = ptr_q;
    end
  end

  // Evaluation sequencer: fetch, multiply-add, repeat degree times.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      dbl_q <= 1'b0;
      arg_q <= 64'h0;
      acc_q <= 64'h0;
      coef_q <= 64'h0;
      ptr_q <= 32'h0000_0000;
      left_q <= 6'h00;
      first_q <= 1'b0;
      unf_q <= 1'b0;
      go_q <= 1'b0;
      mem_req_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      go_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // Requests are taken only here, so a start while busy is ignored.
          if (start_ok & is_poly & !early_fault) begin
            state_q <= ST_FETCH;
            dbl_q <= (opc == OPC_HORNER_DOUBLE);
            arg_q <= (opc == OPC_HORNER_DOUBLE) ? req_i.arg : {32'h0000_0000, req_i.arg[31:0]};
            ptr_q <= req_i.tbladdr; // highest order coefficient first
            left_q <= req_i.degree[5:0];
            first_q <= 1'b1;
            unf_q <= 1'b0;
            mem_req_o <= 1'b1;
            busy_o <= 1'b1;
          end
        end
        ST_FETCH: begin
          if (p_fault | p_first_end) begin
            // The pointer stays on a faulting coefficient.
            state_q <= ST_IDLE;
            mem_req_o <= 1'b0;
            busy_o <= 1'b0;
          end else if (fetch_ok) begin
            ptr_q <= ptr_q + step; // next lower order at the next entry
            first_q <= 1'b0;
            if (first_q) begin
              acc_q <= coef; // start from the top coefficient
            end else begin
              coef_q <= coef;
              go_q <= 1'b1;
              state_q <= ST_MAC;
              mem_req_o <= 1'b0;
            end
          end
        end
        ST_MAC: begin
          if (p_ovf | p_end_ok) begin
            state_q <= ST_IDLE;
            busy_o <= 1'b0;
          end else if (mac_done) begin
            // An underflowed step continues from zero.
            acc_q <= mac_unf ? 64'h0 : mac_res;
            unf_q <= unf_q | mac_unf;
            left_q <= left_q - 6'h01;
            state_q <= ST_FETCH;
            mem_req_o <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          mem_req_o <= 1'b0;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  assign mem_addr_o = ptr_q;
  assign mem_dbl_o = dbl_q;

  // Product truncation and the single rounding live in the multiply-add.
  lsp_fmac u_fmac (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .go_i(go_q),
    .dbl_i(dbl_q),
    .a_i(arg_q),
    .b_i(acc_q),
    .c_i(coef_q),
    .valid_o(mac_valid),
    .res_o(mac_res),
    .ovf_o(mac_ovf),
    .unf_o(mac_unf)
  );

  // Completion: every finished operation gives one done strobe with its results.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      done_o <= 1'b0;
      result_o <= 64'h0;
      dst_wr_o <= 1'b0;
      regs_o <= '0;
      regs_wr_o <= 1'b0;
      cc_o <= '0;
      exc_o <= '0;
      fpd_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      dst_wr_o <= 1'b0;
      regs_wr_o <= 1'b0;
      if (start_ok & !is_poly) begin
        done_o <= 1'b1;
        result_o <= op_res;
        dst_wr_o <= op_wr;
        cc_o <= op_cc;
        exc_o <= op_exc;
        fpd_o <= 1'b0;
      end else if (start_ok & early_fault) begin
        // Degree or argument is bad before anything was done.
        done_o <= 1'b1;
        cc_o <= '0;
        exc_o <= '{int_ovf: 1'b0, flt_ovf: 1'b0, flt_unf: 1'b0, rsvd_op: 1'b1};
        fpd_o <= 1'b0;
      end else if (p_fault) begin
        // Once the top coefficient is in, a fault can only be a coefficient.
        done_o <= 1'b1;
        regs_o <= '{r2: 32'h0000_0000, r3: ptr_q, r4: 32'h0000_0000, r5: 32'h0000_0000};
        regs_wr_o <= 1'b1;
        cc_o <= '0;
        exc_o <= '{int_ovf: 1'b0, flt_ovf: 1'b0, flt_unf: 1'b0, rsvd_op: 1'b1};
        fpd_o <= !first_q;
      end else if (p_ovf) begin
        done_o <= 1'b1;
        result_o <= {32'h0000_0000, RSVD_PATTERN};
        dst_wr_o <= 1'b1;
        regs_o <= '{r2: 32'h0000_0000, r3: ptr_q, r4: 32'h0000_0000, r5: 32'h0000_0000};
        regs_wr_o <= 1'b1;
        cc_o <= '{n: 1'b1, z: 1'b0, v: 1'b1, c: 1'b0};
        // Any underflow seen earlier is dropped here.
        exc_o <= '{int_ovf: 1'b0, flt_ovf: 1'b1, flt_unf: 1'b0, rsvd_op: 1'b0};
        fpd_o <= 1'b0;
      end else if (p_end_ok) begin
        done_o <= 1'b1;
        result_o <= dbl_q ? fin_acc : {32'h0000_0000, fin_acc[31:0]};
        dst_wr_o <= 1'b1;
        regs_o <= '{r2: 32'h0000_0000, r3: fin_ptr, r4: 32'h0000_0000, r5: 32'h0000_0000};
        regs_wr_o <= 1'b1;
        cc_o <= '{n: fin_acc[15], z: (fin_acc[31:0] == 32'h0000_0000), v: 1'b0, c: 1'b0};
        exc_o <= '{int_ovf: 1'b0, flt_ovf: 1'b0, flt_unf: unf_q | (mac_done & mac_unf), rsvd_op: 1'b0};
        fpd_o <= 1'b0;
      end
    end
  end

endmodule : lsp_unit

// file: sim/lsp_unit_properties.sv
`timescale 1ns/1ps
// Port checks on the unit; one clock domain only.
module lsp_unit_chk import lsp_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire lsp_req_t req_i,
  input wire logic carry_i,
  input wire logic mem_ack_i,
  input wire logic mem_req_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [63:0] result_o,
  input wire logic dst_wr_o,
  input wire logic regs_wr_o,
  input wire lsp_cc_t cc_o,
  input wire lsp_exc_t exc_o,
  input wire logic fpd_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  logic tk; // A request is accepted now.
  logic pl; // The request is an evaluation.
  logic [7:0] op; // Opcode presented.
  assign op = req_i.opcode;
  assign tk = start_i && !busy_o;
  assign pl = op == OPC_HORNER_SINGLE || op == OPC_HORNER_DOUBLE;
  property p_quick; tk && !pl |=> done_o; endproperty
  a_quick: assert property (p_quick) else $error("late done");
  property p_test; tk && (op == 8'h93 || op == 8'hB3 || op == 8'hD3) |=>
    !dst_wr_o && !cc_o.v && cc_o.c == $past(carry_i); endproperty
  a_test: assert property (p_test) else $error("bit test wrong");
  property p_shift; tk && (op == OPC_ARITH_SHIFT_LONG || op == OPC_ARITH_SHIFT_QUAD) |=>
    !cc_o.c && cc_o.v == exc_o.int_ovf; endproperty
  a_shift: assert property (p_shift) else $error("shift flags wrong");
  property p_rot; tk && op == OPC_ROTATE_LONG |=>
    !cc_o.v && cc_o.c == $past(carry_i) && cc_o.z == (result_o[31:0] == 32'h0); endproperty
  a_rot: assert property (p_rot) else $error("rotate flags wrong");
  property p_pcc; done_o && regs_wr_o && !exc_o.rsvd_op |->
    !cc_o.c && cc_o.n == result_o[15] && cc_o.v == exc_o.flt_ovf; endproperty
  a_pcc: assert property (p_pcc) else $error("evaluation flags wrong");
  property p_ovf; done_o && exc_o.flt_ovf |-> result_o == {32'h0, RSVD_PATTERN}; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow result wrong");
  property p_both; done_o |-> !(exc_o.flt_ovf && exc_o.flt_unf); endproperty
  a_both: assert property (p_both) else $error("both traps raised");
  property p_addr; mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o); endproperty
  a_addr: assert property (p_addr) else $error("fetch not held");
  property p_deg; tk && pl && req_i.degree > DEGREE_LIMIT |=>
    done_o && exc_o.rsvd_op && !fpd_o && !dst_wr_o; endproperty
  a_deg: assert property (p_deg) else $error("degree fault wrong");
  property p_busy; $fell(busy_o) |-> done_o; endproperty
  a_busy: assert property (p_busy) else $error("busy fell early");
endmodule : lsp_unit_chk
bind lsp_unit lsp_unit_chk u_chk (.clk_sys_i, .resetn_i, .start_i, .req_i, .carry_i, .mem_ack_i, .mem_req_o,
  .mem_addr_o, .busy_o, .done_o, .result_o, .dst_wr_o, .regs_wr_o, .cc_o, .exc_o, .fpd_o);

// file: sim/lsp_coef_mem.sv
`timescale 1ns/1ps
// Coefficient table model; answers at once or after three waits.
module lsp_coef_mem (
  input wire logic clk_sys_i,
  input wire logic slow_i,
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  input wire logic dbl_i,
  output logic ack_o,
  output logic [63:0] rdata_o
);
  logic [63:0] table_q [0:15]; // Loaded by the bench.
  logic [1:0] wait_q; // Waits left before answering.
  initial begin
    ack_o = 1'b0;
    rdata_o = 64'h0;
    wait_q = 2'h0;
  end
  // Data is inverted each idle cycle so a stale value never passes.
  always @(posedge clk_sys_i) begin
    if (req_i && !ack_o && wait_q == 2'h0) begin
      ack_o <= 1'b1;
      rdata_o <= table_q[dbl_i ? addr_i[6:3] : addr_i[5:2]];
      wait_q <= {slow_i, slow_i};
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) wait_q <= wait_q - 2'h1;
    end
  end
endmodule : lsp_coef_mem

// file: sim/lsp_unit_tb.sv
`timescale 1ns/1ps
// Drives the unit as the decode side does and checks its answers.
module lsp_unit_tb import lsp_pkg::*;;
  typedef struct packed {logic [7:0] o; logic [7:0] c; logic [63:0] s; logic [63:0] r; logic v;} lsp_sh_t;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic start_i = 1'b0;
  logic carry_i = 1'b0;
  logic slow = 1'b0;
  lsp_req_t req_i = '0;
  logic mem_ack_i, mem_req_o, mem_dbl_o, busy_o, done_o, dst_wr_o, regs_wr_o, fpd_o;
  logic [31:0] mem_addr_o, b, r, s32, d32;
  logic [63:0] mem_rdata_i, result_o;
  logic [7:0] opc;
  lsp_regs_t regs_o;
  lsp_cc_t cc_o;
  lsp_exc_t exc_o;
  int num_errors = 0;
  int checks = 0;
  logic [3:0] nibs [7] = '{4'h3, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
  lsp_sh_t sh [10] = '{'{8'h78, 8'h04, 64'hF1, 64'hF10, 1'b0}, '{8'h78, 8'h01, 64'h4000_0000, 64'h8000_0000, 1'b1},
    '{8'h78, 8'hFD, 64'h8000_0010, 64'hF000_0002, 1'b0}, '{8'h78, 8'h21, 64'h1, 64'h0, 1'b1},
    '{8'h78, 8'hE0, 64'h8000_0000, 64'hFFFF_FFFF, 1'b0}, '{8'h97, 8'hC1, {1'b1, 63'h0}, '1, 1'b0},
    '{8'h97, 8'h41, 64'h1, 64'h0, 1'b1}, '{8'h97, 8'h00, 64'h8012_0000_0000_0005, 64'h8012_0000_0000_0005, 1'b0},
    '{8'h9C, 8'h04, 64'h8000_0001, 64'h18, 1'b0}, '{8'h9C, 8'hFC, 64'h8000_0001, 64'h1800_0000, 1'b0}};
  lsp_unit u_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .start_i(start_i), .req_i(req_i), .carry_i(carry_i),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
    .mem_dbl_o(mem_dbl_o), .busy_o(busy_o), .done_o(done_o), .result_o(result_o), .dst_wr_o(dst_wr_o),
    .regs_o(regs_o), .regs_wr_o(regs_wr_o), .cc_o(cc_o), .exc_o(exc_o), .fpd_o(fpd_o));
  lsp_coef_mem u_mem (.clk_sys_i(clk_sys_i), .slow_i(slow), .req_i(mem_req_o), .addr_i(mem_addr_o),
    .dbl_i(mem_dbl_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  // The clock runs at 20 MHz.
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One strobe, then a bounded wait for done.
  task automatic go(input lsp_req_t q);
    int n;
    @(negedge clk_sys_i);
    req_i = q;
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 300) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(64'(done_o), 64'h1);
  endtask : go
  task automatic poly(input logic [7:0] o, input logic [63:0] a, input logic [15:0] d, input logic [31:0] t);
    go('{o, 32'h0, 64'h0, 64'h0, 8'h0, a, d, t});
  endtask : poly
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // A hang is cut short well past the expected run length.
  initial begin
    #(50 * 20000);
    num_errors++;
    report_and_stop();
  end
  initial begin
    s32 = 32'h7FA5_90C3;
    d32 = 32'h8F0F_F0F0;
    repeat (16) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    // Every logic opcode at every size; odd low nibbles read the source.
    for (int sz = 0; sz < 3; sz++) begin
      foreach (nibs[i]) begin
        opc = {1'b1, sz[1:0], nibs[i] == 4'h3, nibs[i]};
        carry_i = i[0];
        b = nibs[i][0] ? s32 : d32;
        r = !nibs[i][3] ? (b & 32'hF0F0_8181) : nibs[i][2] ? (b ^ 32'hF0F0_8181) :
          nibs[i][1] ? (b & 32'h0F0F_7E7E) : (b | 32'hF0F0_8181);
        r = r & (sz == 2 ? 32'hFFFF_FFFF : sz == 1 ? 32'h0000_FFFF : 32'h0000_00FF);
        go('{opc, 32'hF0F0_8181, {32'h0, s32}, {32'h0, d32}, 8'h0, 64'h0, 16'h0, 32'h0});
        if (nibs[i] != 4'h3) chk(result_o, {32'h0, r});
        chk({cc_o, exc_o, dst_wr_o}, {r[(8 << sz) - 1], r == 0, 1'b0, carry_i, 4'h0, nibs[i] != 4'h3});
      end
    end
    // Shift and rotate counts of both signs, including zero and past the width.
    carry_i = 1'b1;
    foreach (sh[i]) begin
      go('{sh[i].o, 32'h0, sh[i].s, 64'h0, sh[i].c, 64'h0, 16'h0, 32'h0});
      chk(sh[i].o == OPC_ARITH_SHIFT_QUAD ? result_o : {32'h0, result_o[31:0]}, sh[i].r);
      chk({cc_o, exc_o.int_ovf}, {sh[i].o == 8'h97 ? sh[i].r[63] : sh[i].r[31], sh[i].r == 0, sh[i].v,
        sh[i].o == OPC_ROTATE_LONG, sh[i].v});
    end
    // Evaluations: 0.5 times 0.5 plus 1.0 gives 1.25 only in the right fetch order.
    slow = 1'b1;
    u_mem.table_q[0] = 64'h4000;
    u_mem.table_q[1] = 64'h4080;
    poly(OPC_HORNER_SINGLE, 64'h4000, 16'h1, 32'h100);
    chk(result_o, 64'h40A0);
    chk({regs_o.r2, regs_o.r3, cc_o, exc_o, regs_wr_o}, {32'h0, 32'h108, 8'h0, 1'b1});
    slow = 1'b0;
    u_mem.table_q[8] = 64'h1111_2222_3333_4080;
    poly(OPC_HORNER_DOUBLE, 64'h4080, 16'h0, 32'h140);
    chk({mem_dbl_o, result_o}, {1'b1, 64'h1111_2222_3333_4080});
    chk(regs_o, {32'h0, 32'h148, 64'h0});
    u_mem.table_q[0] = 64'h7FFF;
    u_mem.table_q[1] = 64'h7FFF;
    poly(OPC_HORNER_SINGLE, 64'h7FFF, 16'h1, 32'h100);
    chk({result_o, cc_o, exc_o}, {32'h0, RSVD_PATTERN, 8'hA4});
    u_mem.table_q[0] = 64'h0080;
    u_mem.table_q[1] = 64'h0;
    u_mem.table_q[2] = 64'h4080;
    poly(OPC_HORNER_SINGLE, 64'h0080, 16'h2, 32'h100);
    chk({result_o, cc_o, exc_o, regs_o.r3}, {64'h4080, 8'h02, 32'h10C});
    u_mem.table_q[0] = 64'h4000;
    u_mem.table_q[1] = 64'h8000;
    poly(OPC_HORNER_SINGLE, 64'h4000, 16'h1, 32'h100);
    chk({exc_o, fpd_o, dst_wr_o, regs_o.r3}, {6'h06, 32'h104});
    poly(OPC_HORNER_SINGLE, 64'h4000, 16'h20, 32'h100);
    chk({exc_o, fpd_o, dst_wr_o, regs_wr_o}, 64'h08);
    // A reserved argument faults before any fetch, with first part done clear.
    poly(OPC_HORNER_SINGLE, 64'h8000, 16'h1, 32'h100);
    chk({exc_o, fpd_o, dst_wr_o, regs_wr_o}, 64'h08);
    report_and_stop();
  end
endmodule : lsp_unit_tb
